// ### hdl/rpc_payload_cond.sv
`timescale 1ns/10ps
`include "rpc_cond_regs.svh"
module rpc_payload_cond
    import rpc_cond_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       rst,
    input  wire logic       payload_ctrl_enable,
    input  wire logic       test_path_enable,
    input  wire logic       prbs_direction,
    input  wire logic [1:0] prbs_pattern_framing,
    input  wire logic [2:0] global_substitute_select,
    input  wire logic       signaling_force,
    input  wire logic       signaling_force_level,
    input  wire logic       global_sig_trunk_enable,
    input  wire logic       e1_mode,
    input  wire logic       t1_sig_format,
    input  wire logic [6:0] ind_index,
    input  wire logic       read_not_write,
    input  wire logic [7:0] ind_wdata,
    input  wire logic       ind_start,
    output logic      [7:0] ind_rdata,
    output logic            ind_busy,
    input  wire logic       in_valid,
    input  wire logic       in_frame_start,
    input  wire logic       in_sig_frame,
    input  wire logic [4:0] in_chan,
    input  wire logic [7:0] in_data,
    input  wire logic [3:0] in_sig,
    input  wire logic [7:0] prbs_gen_data,
    output logic            prbs_tap_valid,
    output logic      [7:0] prbs_tap_data,
    output logic      [7:0] prbs_tap_mask,
    output logic            out_valid,
    output logic      [7:0] out_data,
    output logic      [3:0] out_sig
);
    rpc_mem_if mem ();

    rpc_chan_store u_store (
        .core_clk (core_clk),
        .rst      (rst),
        .mem      (mem.store)
    );

    // Indirect access engine
    rpc_acc_state_t acc_state_r;
    rpc_acc_state_t acc_state_nxt;
    rpc_idx_t       acc_idx_r;
    rpc_idx_t       acc_idx_nxt;
    logic           acc_rnw_r;
    logic           acc_rnw_nxt;
    rpc_byte_t      acc_wdata_r;
    rpc_byte_t      acc_wdata_nxt;
    rpc_byte_t      rdata_r;
    rpc_byte_t      rdata_nxt;
    logic           busy_r;
    logic           busy_nxt;
    logic           idx_ok;
    rpc_chan_t      acc_entry;
    logic [1:0]     acc_region;

    assign acc_entry  = acc_idx_r[`RPC_ENTRY_HI:`RPC_ENTRY_LO];
    assign acc_region = acc_idx_r[`RPC_REGION_HI:`RPC_REGION_LO];

    // Holes in the index space read zero and drop writes
    always_comb begin
        idx_ok = 1'b0;
        if (acc_region == `RPC_REGION_CTRL || acc_region == `RPC_REGION_DTRK) begin
            if (e1_mode)
                idx_ok = 1'b1;
            else
                idx_ok = (acc_entry >= `RPC_T1_FIRST) && (acc_entry <= `RPC_T1_LAST);
        end else if (acc_region == `RPC_REGION_STRK) begin
            // Signaling entries skip the E1 timeslots without CAS
            if (e1_mode)
                idx_ok = (acc_entry != `RPC_E1_SIG_ZERO) && (acc_entry != `RPC_E1_SIG_HOLE);
            else
                idx_ok = (acc_entry >= `RPC_T1_FIRST) && (acc_entry <= `RPC_T1_LAST);
        end
    end

    assign mem.acc_idx = acc_idx_r;
    assign mem.wr_data = acc_wdata_r;
    // Store write lasts one cycle, in the last busy cycle
    assign mem.wr_en   = (acc_state_r == RPC_ACC_DO) && !acc_rnw_r && idx_ok;

    always_comb begin
        acc_state_nxt = acc_state_r;
        acc_idx_nxt   = acc_idx_r;
        acc_rnw_nxt   = acc_rnw_r;
        acc_wdata_nxt = acc_wdata_r;
        rdata_nxt     = rdata_r;
        busy_nxt      = busy_r;
        case (acc_state_r)
            RPC_ACC_IDLE: begin
                // Starts while busy are dropped; software polls busy first
                // Request fields latched, so software may change them at once
                if (ind_start) begin
                    acc_idx_nxt   = ind_index;
                    acc_rnw_nxt   = read_not_write;
                    acc_wdata_nxt = ind_wdata;
                    busy_nxt      = 1'b1;
                    acc_state_nxt = RPC_ACC_WAIT;
                end
            end
            RPC_ACC_WAIT: begin
                acc_state_nxt = RPC_ACC_DO;
            end
            RPC_ACC_DO: begin
                // Read result settles together with the fall of busy
                if (acc_rnw_r)
                    rdata_nxt = idx_ok ? mem.acc_rdata : `RPC_ZERO_BYTE;
                busy_nxt      = 1'b0;
                acc_state_nxt = RPC_ACC_IDLE;
            end
            default: begin
                busy_nxt      = 1'b0;
                acc_state_nxt = RPC_ACC_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            acc_state_r <= RPC_ACC_IDLE;
            acc_idx_r   <= `RPC_ZERO_IDX;
            acc_rnw_r   <= 1'b0;
            acc_wdata_r <= `RPC_ZERO_BYTE;
            rdata_r     <= `RPC_ZERO_BYTE;
            busy_r      <= 1'b0;
        end else begin
            acc_state_r <= acc_state_nxt;
            acc_idx_r   <= acc_idx_nxt;
            acc_rnw_r   <= acc_rnw_nxt;
            acc_wdata_r <= acc_wdata_nxt;
            rdata_r     <= rdata_nxt;
            busy_r      <= busy_nxt;
        end
    end

    assign ind_rdata = rdata_r;
    assign ind_busy  = busy_r;

    // Milliwatt phase: shared by all channels, advanced per frame
    // Trade-off: one counter per link instead of one per channel
    logic [2:0] mw_phase_r;
    logic [2:0] mw_phase_nxt;

    always_comb begin
        mw_phase_nxt = mw_phase_r;
        if (in_valid && in_frame_start)
            mw_phase_nxt = mw_phase_r + `RPC_ONE_PH;
    end

    always_ff @(posedge core_clk) begin
        if (rst)
            mw_phase_r <= `RPC_ZERO_PH;
        else
            mw_phase_r <= mw_phase_nxt;
    end

    function automatic rpc_byte_t mw_byte(input logic mu, input logic [2:0] ph);
        rpc_byte_t b;
        case (ph)
            3'h0:    b = mu ? `RPC_MULAW_0 : `RPC_ALAW_0;
            3'h1:    b = mu ? `RPC_MULAW_1 : `RPC_ALAW_1;
            3'h2:    b = mu ? `RPC_MULAW_2 : `RPC_ALAW_2;
            3'h3:    b = mu ? `RPC_MULAW_3 : `RPC_ALAW_3;
            3'h4:    b = mu ? `RPC_MULAW_4 : `RPC_ALAW_4;
            3'h5:    b = mu ? `RPC_MULAW_5 : `RPC_ALAW_5;
            3'h6:    b = mu ? `RPC_MULAW_6 : `RPC_ALAW_6;
            default: b = mu ? `RPC_MULAW_7 : `RPC_ALAW_7;
        endcase
        return b;
    endfunction

    // Data path, one cycle of latency
    // Lookup is combinational so each byte is treated in its own cycle
    assign mem.lk_chan = in_chan;

    logic       tap_valid_r;
    logic       tap_valid_nxt;
    rpc_byte_t  tap_data_r;
    rpc_byte_t  tap_data_nxt;
    rpc_byte_t  tap_mask_r;
    rpc_byte_t  tap_mask_nxt;
    logic       ovalid_r;
    logic       ovalid_nxt;
    rpc_byte_t  odata_r;
    rpc_byte_t  odata_nxt;
    logic [3:0] osig_r;
    logic [3:0] osig_nxt;
    logic [2:0] subst_sel;
    logic       chan_test;
    logic       prbs_hit;
    logic       force_ok;
    rpc_byte_t  prbs_mask;
    rpc_byte_t  inv_mask;

    assign chan_test = mem.lk_ctrl[`RPC_CTL_TEST_BIT];
    assign prbs_hit  = (prbs_pattern_framing == `RPC_PRBS_UNFRAMED) || chan_test;
    // Undefined framing code 3 falls back to 8-bit behaviour
    assign prbs_mask = (prbs_pattern_framing == `RPC_PRBS_7BIT) ?
                       `RPC_MASK_7BIT : `RPC_MASK_ALL;
    // E1 has no robbed bits, so forcing is held off there
    assign force_ok  = signaling_force && !e1_mode && t1_sig_format;

    always_comb begin
        subst_sel = global_substitute_select;
        if (global_substitute_select == `RPC_SUBST_NONE)
            subst_sel = mem.lk_ctrl[`RPC_CTL_SUBST_HI:`RPC_CTL_SUBST_LO];
        inv_mask = `RPC_ZERO_BYTE;
        if (mem.lk_ctrl[`RPC_CTL_MSB_BIT])
            inv_mask = inv_mask | `RPC_MASK_MSB;
        if (mem.lk_ctrl[`RPC_CTL_ODD_BIT])
            inv_mask = inv_mask | `RPC_MASK_ODD;
        if (mem.lk_ctrl[`RPC_CTL_EVEN_BIT])
            inv_mask = inv_mask | `RPC_MASK_EVEN;
    end

    always_comb begin
        ovalid_nxt    = in_valid;
        odata_nxt     = in_data;
        osig_nxt      = in_sig;
        tap_valid_nxt = 1'b0;
        tap_data_nxt  = tap_data_r;
        tap_mask_nxt  = tap_mask_r;
        if (in_valid && payload_ctrl_enable) begin
            // Tap sees the raw byte, ahead of every other treatment
            if (test_path_enable && !prbs_direction && prbs_hit) begin
                tap_valid_nxt = 1'b1;
                tap_data_nxt  = in_data;
                tap_mask_nxt  = prbs_mask;
            end
            case (subst_sel)
                `RPC_SUBST_TRUNK: odata_nxt = mem.lk_dtrk;
                `RPC_SUBST_ALAW:  odata_nxt = mw_byte(1'b0, mw_phase_r);
                `RPC_SUBST_MULAW: odata_nxt = mw_byte(1'b1, mw_phase_r);
                default:          odata_nxt = in_data;
            endcase
            // Robbed-bit position carries the signaling in those frames
            if (force_ok && in_sig_frame)
                odata_nxt[0] = signaling_force_level;
            // Even mask also flips a forced robbed bit
            odata_nxt = odata_nxt ^ inv_mask;
            // Generator bits win over every earlier treatment
            if (test_path_enable && prbs_direction && prbs_hit)
                odata_nxt = (prbs_gen_data & prbs_mask) |
                            (odata_nxt & ~prbs_mask);
            // Signaling pin path: trunk replacement, then forcing
            if (global_sig_trunk_enable || mem.lk_strk[`RPC_STRK_EN_BIT])
                osig_nxt = mem.lk_strk[`RPC_STRK_ABCD_HI:`RPC_STRK_ABCD_LO];
            if (force_ok)
                osig_nxt = signaling_force_level ? `RPC_ONES_SIG : `RPC_ZERO_SIG;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            tap_valid_r <= 1'b0;
            tap_data_r  <= `RPC_ZERO_BYTE;
            tap_mask_r  <= `RPC_ZERO_BYTE;
            ovalid_r    <= 1'b0;
            odata_r     <= `RPC_ZERO_BYTE;
            osig_r      <= `RPC_ZERO_SIG;
        end else begin
            tap_valid_r <= tap_valid_nxt;
            tap_data_r  <= tap_data_nxt;
            tap_mask_r  <= tap_mask_nxt;
            ovalid_r    <= ovalid_nxt;
            odata_r     <= odata_nxt;
            osig_r      <= osig_nxt;
        end
    end

    assign prbs_tap_valid = tap_valid_r;
    assign prbs_tap_data  = tap_data_r;
    assign prbs_tap_mask  = tap_mask_r;
    assign out_valid      = ovalid_r;
    assign out_data       = odata_r;
    assign out_sig        = osig_r;
endmodule

// ### hdl/rpc_cond_regs.svh
`ifndef RPC_COND_REGS_SVH
`define RPC_COND_REGS_SVH

// Indirect index map: region in index[6:5], entry in index[4:0]
`define RPC_IDX_W          7
`define RPC_REGION_CTRL    2'h0
`define RPC_REGION_DTRK    2'h1
`define RPC_REGION_STRK    2'h2
`define RPC_T1_FIRST       5'h01
`define RPC_T1_LAST        5'h18
`define RPC_E1_SIG_HOLE    5'h10
`define RPC_E1_SIG_ZERO    5'h00
`define RPC_REGION_HI      6
`define RPC_REGION_LO      5
`define RPC_ENTRY_HI       4
`define RPC_ENTRY_LO       0
`define RPC_ZERO_IDX       7'h00

// Channel control byte layout
`define RPC_CTL_TEST_BIT   7
`define RPC_CTL_SUBST_HI   6
`define RPC_CTL_SUBST_LO   4
`define RPC_CTL_MSB_BIT    2
`define RPC_CTL_ODD_BIT    1
`define RPC_CTL_EVEN_BIT   0

// Signaling trunk byte layout
`define RPC_STRK_EN_BIT    4
`define RPC_STRK_ABCD_HI   3
`define RPC_STRK_ABCD_LO   0

// Substitution codes; zero in the global field defers to the channel
`define RPC_SUBST_NONE     3'h0
`define RPC_SUBST_TRUNK    3'h1
`define RPC_SUBST_ALAW     3'h2
`define RPC_SUBST_MULAW    3'h3

// PRBS framing codes
`define RPC_PRBS_UNFRAMED  2'h0
`define RPC_PRBS_8BIT      2'h1
`define RPC_PRBS_7BIT      2'h2

// Bit masks; bit 1 of a channel is data[7]
`define RPC_MASK_MSB       8'h80
`define RPC_MASK_ODD       8'hAA
`define RPC_MASK_EVEN      8'h55
`define RPC_MASK_7BIT      8'hFE
`define RPC_MASK_ALL       8'hFF

// Milliwatt patterns, byte 1 first, bit 7 is the MSB
`define RPC_ALAW_0 8'h34
`define RPC_ALAW_1 8'h21
`define RPC_ALAW_2 8'h21
`define RPC_ALAW_3 8'h34
`define RPC_ALAW_4 8'hB4
`define RPC_ALAW_5 8'hA1
`define RPC_ALAW_6 8'hA1
`define RPC_ALAW_7 8'hB4
`define RPC_MULAW_0 8'h1E
`define RPC_MULAW_1 8'h0B
`define RPC_MULAW_2 8'h0B
`define RPC_MULAW_3 8'h1E
`define RPC_MULAW_4 8'h9E
`define RPC_MULAW_5 8'h8B
`define RPC_MULAW_6 8'h8B
`define RPC_MULAW_7 8'h9E

`define RPC_ZERO_BYTE      8'h00
`define RPC_ZERO_SIG       4'h0
`define RPC_ONES_SIG       4'hF
`define RPC_ZERO_PH        3'h0
`define RPC_ONE_PH         3'h1

`endif

// ### hdl/rpc_cond_pkg.sv
package rpc_cond_pkg;
    typedef logic [7:0] rpc_byte_t;
    typedef logic [6:0] rpc_idx_t;
    typedef logic [4:0] rpc_chan_t;
    typedef enum logic [2:0] {
        RPC_ACC_IDLE = 3'b001,
        RPC_ACC_WAIT = 3'b010,
        RPC_ACC_DO   = 3'b100
    } rpc_acc_state_t;
endpackage

// ### hdl/rpc_mem_if.sv
`timescale 1ns/10ps
interface rpc_mem_if;
    import rpc_cond_pkg::*;
    logic      wr_en;
    rpc_idx_t  acc_idx;
    rpc_byte_t wr_data;
    rpc_byte_t acc_rdata;
    rpc_chan_t lk_chan;
    rpc_byte_t lk_ctrl;
    rpc_byte_t lk_dtrk;
    rpc_byte_t lk_strk;
    modport master (output wr_en, acc_idx, wr_data, lk_chan,
                    input  acc_rdata, lk_ctrl, lk_dtrk, lk_strk);
    modport store  (input  wr_en, acc_idx, wr_data, lk_chan,
                    output acc_rdata, lk_ctrl, lk_dtrk, lk_strk);
endinterface

// ### hdl/rpc_chan_store.sv
`timescale 1ns/10ps
`include "rpc_cond_regs.svh"
module rpc_chan_store
    import rpc_cond_pkg::*;
(
    input  wire logic   core_clk,
    input  wire logic   rst,
    rpc_mem_if.store    mem
);
    rpc_byte_t ctrl_r [32];
    rpc_byte_t dtrk_r [32];
    rpc_byte_t strk_r [32];
    rpc_byte_t ctrl_nxt [32];
    rpc_byte_t dtrk_nxt [32];
    rpc_byte_t strk_nxt [32];
    logic [1:0] region;
    rpc_chan_t  entry;

    assign region = mem.acc_idx[`RPC_REGION_HI:`RPC_REGION_LO];
    assign entry  = mem.acc_idx[`RPC_ENTRY_HI:`RPC_ENTRY_LO];

    genvar g;
    generate
        for (g = 0; g < 32; g++) begin : g_entry
            always_comb begin
                ctrl_nxt[g] = ctrl_r[g];
                dtrk_nxt[g] = dtrk_r[g];
                strk_nxt[g] = strk_r[g];
                if (mem.wr_en && entry == 5'(g)) begin
                    if (region == `RPC_REGION_CTRL)
                        ctrl_nxt[g] = mem.wr_data;
                    else if (region == `RPC_REGION_DTRK)
                        dtrk_nxt[g] = mem.wr_data;
                    else if (region == `RPC_REGION_STRK)
                        strk_nxt[g] = mem.wr_data;
                end
            end
            always_ff @(posedge core_clk) begin
                if (rst) begin
                    ctrl_r[g] <= `RPC_ZERO_BYTE;
                    dtrk_r[g] <= `RPC_ZERO_BYTE;
                    strk_r[g] <= `RPC_ZERO_BYTE;
                end else begin
                    ctrl_r[g] <= ctrl_nxt[g];
                    dtrk_r[g] <= dtrk_nxt[g];
                    strk_r[g] <= strk_nxt[g];
                end
            end
        end
    endgenerate

    always_comb begin
        case (region)
            `RPC_REGION_CTRL: mem.acc_rdata = ctrl_r[entry];
            `RPC_REGION_DTRK: mem.acc_rdata = dtrk_r[entry];
            `RPC_REGION_STRK: mem.acc_rdata = strk_r[entry];
            default:          mem.acc_rdata = `RPC_ZERO_BYTE;
        endcase
    end

    assign mem.lk_ctrl = ctrl_r[mem.lk_chan];
    assign mem.lk_dtrk = dtrk_r[mem.lk_chan];
    assign mem.lk_strk = strk_r[mem.lk_chan];
endmodule

// ### verification/rpc_cond_checker.sv
`timescale 1ns/10ps
module rpc_cond_checker (
    input wire logic       core_clk,
    input wire logic       rst,
    input wire logic       payload_ctrl_enable,
    input wire logic       test_path_enable,
    input wire logic       prbs_direction,
    input wire logic [1:0] prbs_pattern_framing,
    input wire logic       signaling_force,
    input wire logic       signaling_force_level,
    input wire logic       e1_mode,
    input wire logic       t1_sig_format,
    input wire logic       ind_start,
    input wire logic       ind_busy,
    input wire logic       in_valid,
    input wire logic [7:0] in_data,
    input wire logic [3:0] in_sig,
    input wire logic [7:0] prbs_gen_data,
    input wire logic       prbs_tap_valid,
    input wire logic [7:0] prbs_tap_data,
    input wire logic [7:0] prbs_tap_mask,
    input wire logic       out_valid,
    input wire logic [7:0] out_data,
    input wire logic [3:0] out_sig
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    // Force is legal only for robbed-bit T1 framings
    wire act = payload_ctrl_enable & test_path_enable;
    wire frc = payload_ctrl_enable & signaling_force & ~e1_mode & t1_sig_format;
    wire unf = prbs_pattern_framing == 2'h0;
    AST_LAT: assert property (in_valid |=> out_valid)
        else $error("out_valid not one cycle after in_valid");
    AST_NOV: assert property (!in_valid |=> !out_valid && !prbs_tap_valid)
        else $error("output pulse without input byte");
    AST_PASS: assert property (in_valid && !payload_ctrl_enable |=>
        out_data == $past(in_data) && out_sig == $past(in_sig))
        else $error("disabled stage altered the byte");
    AST_TAP: assert property (in_valid && act && !prbs_direction && unf |=>
        prbs_tap_valid && prbs_tap_data == $past(in_data) && prbs_tap_mask == 8'hFF)
        else $error("unframed tap missing or wrong");
    AST_NOTAP: assert property (in_valid && !(act && !prbs_direction) |=> !prbs_tap_valid)
        else $error("tap without tap direction");
    AST_INS: assert property (in_valid && act && prbs_direction && unf |=>
        out_data == $past(prbs_gen_data))
        else $error("unframed insertion wrong");
    AST_FRC: assert property (in_valid && frc |=>
        out_sig == {4{$past(signaling_force_level)}})
        else $error("forced signaling wrong");
    AST_BUSY: assert property (ind_start && !ind_busy |=> ind_busy [*2] ##1 !ind_busy)
        else $error("busy timing wrong");
    COV_TAP: cover property (prbs_tap_valid);
    COV_FRC: cover property (in_valid && frc);
    COV_ACC: cover property (ind_start && !ind_busy ##3 !ind_busy);
endmodule
bind rpc_payload_cond rpc_cond_checker i_chk (
    .core_clk(core_clk), .rst(rst), .payload_ctrl_enable(payload_ctrl_enable),
    .test_path_enable(test_path_enable), .prbs_direction(prbs_direction),
    .prbs_pattern_framing(prbs_pattern_framing), .signaling_force(signaling_force),
    .signaling_force_level(signaling_force_level), .e1_mode(e1_mode),
    .t1_sig_format(t1_sig_format), .ind_start(ind_start), .ind_busy(ind_busy),
    .in_valid(in_valid), .in_data(in_data), .in_sig(in_sig), .prbs_gen_data(prbs_gen_data),
    .prbs_tap_valid(prbs_tap_valid), .prbs_tap_data(prbs_tap_data),
    .prbs_tap_mask(prbs_tap_mask), .out_valid(out_valid), .out_data(out_data),
    .out_sig(out_sig)
);

// ### verification/rpc_far_model.sv
`timescale 1ns/10ps
module rpc_far_model
    import rpc_cond_pkg::*;
(
    input  wire logic core_clk,
    input  wire logic rst,
    input  wire logic tap_valid,
    output rpc_byte_t gen_data,
    output rpc_byte_t tap_count
);
    rpc_byte_t gen_r, gen_nxt, cnt_r, cnt_nxt;
    // Generator moves every cycle so a stale byte cannot match by luck
    always_comb begin
        gen_nxt = {gen_r[6:0], gen_r[7] ^ gen_r[5] ^ gen_r[4] ^ gen_r[3]};
        cnt_nxt = cnt_r + {7'h00, tap_valid};
    end
    always_ff @(posedge core_clk) begin
        if (rst) begin
            gen_r <= 8'hA5;
            cnt_r <= 8'h00;
        end else begin
            gen_r <= gen_nxt;
            cnt_r <= cnt_nxt;
        end
    end
    assign gen_data  = gen_r;
    assign tap_count = cnt_r;
endmodule

// ### verification/testbench.sv
`timescale 1ns/10ps
module testbench;
    import rpc_cond_pkg::*;
    logic       core_clk, rst, en, ten, pdir, sfix, slev, gstk, e1, t1f;
    logic       rnw, st, iv, ifs, isf, busy, tv, ov;
    logic [1:0] pfr;
    logic [2:0] gsel;
    logic [3:0] os, isg;
    rpc_idx_t   idx;
    rpc_chan_t  ich;
    rpc_byte_t  wd, rd, id, gen, td, tm, od, taps, q, tvs, tds, tms;
    int         err_count, checks;
    rpc_byte_t  aw[8] = '{8'h34, 8'h21, 8'h21, 8'h34, 8'hB4, 8'hA1, 8'hA1, 8'hB4};
    rpc_byte_t  mw[8] = '{8'h1E, 8'h0B, 8'h0B, 8'h1E, 8'h9E, 8'h8B, 8'h8B, 8'h9E};
    rpc_byte_t  ic[3] = '{8'h04, 8'h02, 8'h01};
    rpc_byte_t  im[3] = '{8'h80, 8'hAA, 8'h55};
    rpc_payload_cond i_dut (
        .core_clk(core_clk), .rst(rst), .payload_ctrl_enable(en), .test_path_enable(ten),
        .prbs_direction(pdir), .prbs_pattern_framing(pfr), .global_substitute_select(gsel),
        .signaling_force(sfix), .signaling_force_level(slev), .global_sig_trunk_enable(gstk),
        .e1_mode(e1), .t1_sig_format(t1f), .ind_index(idx), .read_not_write(rnw),
        .ind_wdata(wd), .ind_start(st), .ind_rdata(rd), .ind_busy(busy), .in_valid(iv),
        .in_frame_start(ifs), .in_sig_frame(isf), .in_chan(ich), .in_data(id),
        .in_sig(isg), .prbs_gen_data(gen), .prbs_tap_valid(tv), .prbs_tap_data(td),
        .prbs_tap_mask(tm), .out_valid(ov), .out_data(od), .out_sig(os)
    );
    rpc_far_model i_far (
        .core_clk(core_clk), .rst(rst), .tap_valid(tv), .gen_data(gen), .tap_count(taps)
    );
    task automatic print_verdict;
        $display("Counts: %0d compared, %0d mismatched", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic cmp8(string n, rpc_byte_t e, rpc_byte_t g);
        checks++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic acc(logic r, rpc_idx_t a, rpc_byte_t w);
        int n;
        @(posedge core_clk);
        st <= 1'b1;
        rnw <= r;
        idx <= a;
        wd <= w;
        @(posedge core_clk);
        st <= 1'b0;
        n = 0;
        @(negedge core_clk);
        while (busy !== 1'b0 && n < 20) begin
            @(negedge core_clk);
            n++;
        end
        if (n == 20) begin
            err_count++;
            print_verdict();
        end
        q = rd;
        @(posedge core_clk);
    endtask
    // Generator byte is read between edges, where the design samples it
    task automatic send(rpc_chan_t c, rpc_byte_t d, logic f, rpc_byte_t ed, rpc_byte_t m,
                        logic [3:0] es);
        rpc_byte_t g;
        @(posedge core_clk);
        iv <= 1'b1;
        ich <= c;
        id <= d;
        ifs <= f;
        @(negedge core_clk);
        g = gen;
        @(posedge core_clk);
        iv <= 1'b0;
        ifs <= 1'b0;
        @(negedge core_clk);
        tvs = {7'h00, tv};
        tds = td;
        tms = tm;
        cmp8("out_valid", 8'h01, {7'h00, ov});
        cmp8("out_data", (ed & ~m) | (g & m), od);
        cmp8("out_sig", {4'h0, es}, {4'h0, os});
        @(posedge core_clk);
    endtask
    task automatic done(string n);
        $display("Test %s finished", n);
    endtask
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    initial begin
        rst = 1'b1;
        {en, ten, pdir, sfix, slev, gstk, e1, t1f, rnw, st, iv, ifs, isf} = '0;
        {pfr, gsel, idx, ich, wd, id, err_count, checks} = '0;
        isg = 4'h6;
        repeat (20) @(posedge core_clk);
        rst <= 1'b0;
        @(negedge core_clk);
        cmp8("busy", 8'h00, {7'h00, busy});
        acc(1'b0, 7'h05, 8'h14);
        acc(1'b1, 7'h05, 8'h00);
        cmp8("rdata", 8'h14, q);
        acc(1'b0, 7'h00, 8'hFF);
        acc(1'b1, 7'h00, 8'h00);
        cmp8("rdata", 8'h00, q);
        e1 <= 1'b1;
        acc(1'b0, 7'h00, 8'h11);
        acc(1'b1, 7'h00, 8'h00);
        cmp8("rdata", 8'h11, q);
        acc(1'b0, 7'h50, 8'h1F);
        acc(1'b1, 7'h50, 8'h00);
        cmp8("rdata", 8'h00, q);
        e1 <= 1'b0;
        acc(1'b0, 7'h25, 8'h5A);
        acc(1'b0, 7'h09, 8'h80);
        done("indirect");
        gsel <= 3'h1;
        isg <= 4'h9;
        send(5'h05, 8'h33, 1'b0, 8'h33, 8'h00, 4'h9);
        en <= 1'b1;
        isg <= 4'h6;
        send(5'h06, 8'h33, 1'b0, 8'h00, 8'h00, 4'h6);
        gsel <= 3'h0;
        send(5'h05, 8'h33, 1'b0, 8'hDA, 8'h00, 4'h6);
        send(5'h06, 8'h33, 1'b0, 8'h33, 8'h00, 4'h6);
        done("substitution");
        gsel <= 3'h2;
        for (int k = 0; k < 8; k++) send(5'h06, 8'h33, 1'b1, aw[k], 8'h00, 4'h6);
        gsel <= 3'h3;
        for (int k = 0; k < 8; k++) send(5'h06, 8'h33, 1'b1, mw[k], 8'h00, 4'h6);
        gsel <= 3'h0;
        done("milliwatt");
        for (int k = 0; k < 3; k++) begin
            acc(1'b0, 7'h07, ic[k]);
            send(5'h07, 8'h0F, 1'b0, 8'h0F ^ im[k], 8'h00, 4'h6);
        end
        done("invert");
        {sfix, slev, t1f, isf} <= 4'hF;
        send(5'h06, 8'h32, 1'b0, 8'h33, 8'h00, 4'hF);
        slev <= 1'b0;
        send(5'h06, 8'h33, 1'b0, 8'h32, 8'h00, 4'h0);
        e1 <= 1'b1;
        send(5'h06, 8'h33, 1'b0, 8'h33, 8'h00, 4'h6);
        {e1, t1f} <= 2'h0;
        send(5'h06, 8'h33, 1'b0, 8'h33, 8'h00, 4'h6);
        {sfix, isf} <= 2'h0;
        done("force");
        acc(1'b0, 7'h46, 8'h13);
        send(5'h06, 8'h33, 1'b0, 8'h33, 8'h00, 4'h3);
        acc(1'b0, 7'h48, 8'h09);
        send(5'h08, 8'h33, 1'b0, 8'h33, 8'h00, 4'h6);
        gstk <= 1'b1;
        send(5'h08, 8'h33, 1'b0, 8'h33, 8'h00, 4'h9);
        {sfix, slev, t1f} <= 3'h7;
        send(5'h08, 8'h33, 1'b0, 8'h33, 8'h00, 4'hF);
        {sfix, slev, t1f, gstk} <= 4'h0;
        done("signaling");
        {ten, pfr} <= 3'h5;
        send(5'h06, 8'h33, 1'b0, 8'h33, 8'h00, 4'h3);
        cmp8("tap_valid", 8'h00, tvs);
        send(5'h09, 8'hC3, 1'b0, 8'hC3, 8'h00, 4'h6);
        cmp8("tap_data", 8'hC3, tds);
        cmp8("tap_mask", 8'hFF, tms);
        pfr <= 2'h2;
        send(5'h09, 8'hC3, 1'b0, 8'hC3, 8'h00, 4'h6);
        cmp8("tap_mask", 8'hFE, tms);
        pfr <= 2'h0;
        send(5'h06, 8'h33, 1'b0, 8'h33, 8'h00, 4'h3);
        cmp8("tap_valid", 8'h01, tvs);
        // Count settles one edge after the last tap pulse
        @(negedge core_clk);
        cmp8("tap_count", 8'h03, taps);
        done("extract");
        pdir <= 1'b1;
        send(5'h07, 8'h33, 1'b0, 8'h33, 8'hFF, 4'h6);
        pfr <= 2'h1;
        send(5'h06, 8'h33, 1'b0, 8'h33, 8'h00, 4'h3);
        send(5'h09, 8'hC3, 1'b0, 8'hC3, 8'hFF, 4'h6);
        pfr <= 2'h2;
        send(5'h09, 8'hC3, 1'b0, 8'hC3, 8'hFE, 4'h6);
        done("insert");
        print_verdict();
    end
endmodule
